// *** rtl/fft_bfly_defs.svh ***
// Operation
// - each butterfly yields A plus B times W, and A minus B times W
// - four real products and six real sums or differences per butterfly
// - schedule repeats every four microcycles; one butterfly starts and ends per four
// - up to three butterflies are in flight in different stages at once
// - in steady loop both ALUs and the multiplier work every microcycle
// - no resource serves two operations within one microcycle
// - control word is 128 bits with a field for each resource
// - fields cover ALUs, multiplier, addressing, memory, address pipeline, shifter, clock, cond mux
// - base microcycle covers 141 ns; 178 ns condition path asks a stretched cycle
// - microword has an operation part and a next-address part
`ifndef FFT_BFLY_DEFS_SVH
`define FFT_BFLY_DEFS_SVH

// microword geometry
`define MW_W 128
`define MW_SEQ_LSB 0
`define MW_SEQ_W 16
`define MW_RALU_LSB 16
`define MW_RALU_W 29
`define MW_IALU_LSB 45
`define MW_IALU_W 29
`define MW_MULT_LSB 74
`define MW_MULT_W 6
`define MW_SHIFT_LSB 80
`define MW_SHIFT_W 4
`define MW_APIPE_LSB 84
`define MW_APIPE_W 4
`define MW_DADDR_LSB 88
`define MW_CADDR_LSB 98
`define MW_RUN_BIT 108
`define MW_CCSEL_LSB 109
`define MW_CCSEL_W 5
`define MW_STRETCH_BIT 114
`define MW_MEM_EN_BIT 116
`define MW_SYNC_BIT 117
`define MW_OVF_CLR_BIT 118

// data and address widths
`define DATA_W 16
`define ADDR_W 10
`define COND_PIN_W 16

// address pipeline depths
`define B_STACK_DEPTH 3
`define A_STACK_DEPTH 2

// microcycle timing
`define CLK_PERIOD_NS 5
`define DATA_PATH_NS 141
`define COND_PATH_NS 178
`define BASE_CYC ((`DATA_PATH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_CYC ((`COND_PATH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/fft_bfly_pkg.sv ***
`include "fft_bfly_defs.svh"

package fft_bfly_pkg;

  // loop position inside the four-microcycle schedule
  typedef enum logic [3:0] {
    PH0 = 4'b0001,
    PH1 = 4'b0010,
    PH2 = 4'b0100,
    PH3 = 4'b1000
  } phase_e;

  typedef struct packed {
    logic signed [`DATA_W-1:0] re;
    logic signed [`DATA_W-1:0] im;
  } cplx_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [`ADDR_W-1:0] addr;
  } mem_req_s;

  typedef struct packed {
    logic [11:0] branch_addr;
    logic [3:0] instr;
  } seq_ctl_s;

endpackage

// *** rtl/cycle_len_ctl.sv ***
`timescale 1ns/1ps
`include "fft_bfly_defs.svh"

module cycle_len_ctl #(
  parameter int BASE_CYC = `BASE_CYC,
  parameter int LONG_CYC = `LONG_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // length request
  input wire logic stretch,
  // end of microcycle
  output logic step
);

  logic [7:0] cnt_ff;
  logic step_ff;
  wire [7:0] last_base = 8'(BASE_CYC - 1);
  wire [7:0] last_long = 8'(LONG_CYC - 1);
  // live request decides: the word holds still for the whole microcycle
  wire [7:0] last_cnt = stretch ? last_long : last_base;
  wire at_end = (cnt_ff >= last_cnt);

  // free running microcycle counter, one pulse per microcycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 8'h00;
      step_ff <= 1'b0;
    end else begin
      cnt_ff <= at_end ? 8'h00 : cnt_ff + 8'h01;
      step_ff <= at_end;
    end
  end

  assign step = step_ff;

endmodule

// *** rtl/fft_butterfly_pipeline.sv ***
`timescale 1ns/1ps
`include "fft_bfly_defs.svh"

module fft_butterfly_pipeline
  import fft_bfly_pkg::*;
#(
  parameter int BASE_CYC = `BASE_CYC,
  parameter int LONG_CYC = `LONG_CYC,
  parameter int B_DEPTH = `B_STACK_DEPTH,
  parameter int A_DEPTH = `A_STACK_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // microword from the pipeline register
  input wire logic [`MW_W-1:0] uword,
  // data memory
  input wire cplx_s mem_rdata,
  output mem_req_s mem_req,
  output cplx_s mem_wdata,
  // coefficient memory
  input wire cplx_s coef_rdata,
  output logic [`ADDR_W-1:0] coef_addr,
  // condition inputs from outside
  input wire logic [`COND_PIN_W-1:0] cond_pins,
  // toward the sequencer
  output seq_ctl_s seq_ctl,
  output logic cond_out,
  output logic ucyc_step
);

  // microword field decode
  wire [`MW_SEQ_W-1:0] seq_field = uword[`MW_SEQ_LSB +: `MW_SEQ_W];
  wire [`MW_RALU_W-1:0] ralu_field = uword[`MW_RALU_LSB +: `MW_RALU_W];
  wire [`MW_IALU_W-1:0] ialu_field = uword[`MW_IALU_LSB +: `MW_IALU_W];
  wire [`MW_MULT_W-1:0] mult_field = uword[`MW_MULT_LSB +: `MW_MULT_W];
  wire [`MW_SHIFT_W-1:0] shift_amt = uword[`MW_SHIFT_LSB +: `MW_SHIFT_W];
  wire [`MW_APIPE_W-1:0] apipe_field = uword[`MW_APIPE_LSB +: `MW_APIPE_W];
  wire [`ADDR_W-1:0] daddr = uword[`MW_DADDR_LSB +: `ADDR_W];
  wire [`ADDR_W-1:0] caddr = uword[`MW_CADDR_LSB +: `ADDR_W];
  wire [`MW_CCSEL_W-1:0] ccsel = uword[`MW_CCSEL_LSB +: `MW_CCSEL_W];
  wire run = uword[`MW_RUN_BIT];
  wire stretch = uword[`MW_STRETCH_BIT];
  wire mem_en = uword[`MW_MEM_EN_BIT];
  wire sync = uword[`MW_SYNC_BIT];
  wire ovf_clr = uword[`MW_OVF_CLR_BIT];
  wire ralu_en = ralu_field[0];
  wire ialu_en = ialu_field[0];
  wire mult_en = mult_field[0];
  wire apipe_push = apipe_field[0];

  // microcycle length controller
  logic step;
  cycle_len_ctl #(
    .BASE_CYC(BASE_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_cycle_len (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .stretch(stretch),
    .step(step)
  );

  // loop phase
  phase_e phase_ff;
  phase_e nxt_phase;
  wire act = step & run;
  wire ph0 = (phase_ff == PH0);
  wire ph1 = (phase_ff == PH1);
  wire ph2 = (phase_ff == PH2);
  wire ph3 = (phase_ff == PH3);

  // the schedule wraps every fourth microcycle
  always_comb begin
    nxt_phase = phase_ff;
    if (step && sync) begin
      nxt_phase = PH0;
    end else if (act) begin
      unique case (phase_ff)
        PH0: nxt_phase = PH1;
        PH1: nxt_phase = PH2;
        PH2: nxt_phase = PH3;
        PH3: nxt_phase = PH0;
        default: nxt_phase = PH0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= PH0;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // pipeline registers; each one has a single writer per phase
  cplx_s b_ff;
  cplx_s w_ff;
  cplx_s a_ff;
  logic signed [`DATA_W-1:0] mreg_ff;
  logic signed [`DATA_W-1:0] pr_ff;
  logic signed [`DATA_W-1:0] pi_ff;
  logic signed [`DATA_W-1:0] ai_hold_ff;
  logic signed [`DATA_W-1:0] a1r_ff;
  logic signed [`DATA_W-1:0] a1i_ff;
  logic signed [`DATA_W-1:0] b1r_ff;
  logic signed [`DATA_W-1:0] b1i_ff;

  function automatic logic signed [`DATA_W:0] addsub(
    input logic signed [`DATA_W-1:0] x,
    input logic signed [`DATA_W-1:0] y,
    input logic sub
  );
    logic signed [`DATA_W:0] xe;
    logic signed [`DATA_W:0] ye;
    xe = {x[`DATA_W-1], x};
    ye = {y[`DATA_W-1], y};
    addsub = sub ? (xe - ye) : (xe + ye);
  endfunction

  // shared multiplier: BrWr, BiWi, BrWi, BiWr in phases 1, 2, 3, 0
  wire signed [`DATA_W-1:0] m_b = (ph1 | ph3) ? b_ff.re : b_ff.im;
  wire signed [`DATA_W-1:0] m_w = (ph1 | ph0) ? w_ff.re : w_ff.im;
  wire signed [2*`DATA_W-1:0] prod = m_b * m_w;
  // coefficients are fractions; drop the duplicated sign bit
  wire signed [`DATA_W-1:0] prod_q = prod[2*`DATA_W-2:`DATA_W-1];

  // real alu: load BrWr, subtract BiWi, then A.re plus and minus
  wire signed [`DATA_W-1:0] rx = ph2 ? mreg_ff : (ph3 ? pr_ff : a_ff.re);
  wire signed [`DATA_W-1:0] ry = ph2 ? '0 : (ph3 ? mreg_ff : pr_ff);
  wire rsub = ph3 | ph1;
  wire signed [`DATA_W:0] rsum = addsub(rx, ry, rsub);
  wire signed [`DATA_W-1:0] rres = rsum[`DATA_W-1:0];
  wire rovf = rsum[`DATA_W] ^ rsum[`DATA_W-1];

  // imag alu: load BrWi, add BiWr, then A.im plus and minus
  wire signed [`DATA_W-1:0] ix = ph0 ? mreg_ff : (ph1 ? pi_ff : ai_hold_ff);
  wire signed [`DATA_W-1:0] iy = ph0 ? '0 : (ph1 ? mreg_ff : pi_ff);
  wire isub = ph3;
  wire signed [`DATA_W:0] isum = addsub(ix, iy, isub);
  wire signed [`DATA_W-1:0] ires = isum[`DATA_W-1:0];
  wire iovf = isum[`DATA_W] ^ isum[`DATA_W-1];

  wire r_go = act & ralu_en;
  wire i_go = act & ialu_en;
  wire m_go = act & mult_en;
  wire rd_go = act & mem_en;

  // operand capture: B and W in phase 0, A in phase 2
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      b_ff <= '0;
      w_ff <= '0;
      a_ff <= '0;
    end else begin
      if (rd_go && ph0) begin
        b_ff <= mem_rdata;
        w_ff <= coef_rdata;
      end
      if (rd_go && ph2) begin
        a_ff <= mem_rdata;
      end
    end
  end

  // multiplier product register, busy every phase of the loop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mreg_ff <= '0;
    end else if (m_go) begin
      mreg_ff <= prod_q;
    end
  end

  // real alu destinations
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pr_ff <= '0;
      a1r_ff <= '0;
      b1r_ff <= '0;
    end else if (r_go) begin
      if (ph2 || ph3) begin
        pr_ff <= rres;
      end
      if (ph0) begin
        a1r_ff <= rres;
      end
      if (ph1) begin
        b1r_ff <= rres;
      end
    end
  end

  // imag alu destinations; A.im is moved aside so the next A can load
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pi_ff <= '0;
      a1i_ff <= '0;
      b1i_ff <= '0;
      ai_hold_ff <= '0;
    end else if (i_go) begin
      if (ph0 || ph1) begin
        pi_ff <= ires;
      end
      if (ph1) begin
        ai_hold_ff <= a_ff.im;
      end
      if (ph2) begin
        a1i_ff <= ires;
      end
      if (ph3) begin
        b1i_ff <= ires;
      end
    end
  end

  // sticky overflow; a new overflow beats a clear in the same microcycle
  logic ovf_r_ff;
  logic ovf_i_ff;
  wire clr_ovf = step & ovf_clr;
  wire set_ovf_r = r_go & rovf & ~ph2;
  wire set_ovf_i = i_go & iovf & ~ph0;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_r_ff <= 1'b0;
      ovf_i_ff <= 1'b0;
    end else begin
      ovf_r_ff <= (ovf_r_ff & ~clr_ovf) | set_ovf_r;
      ovf_i_ff <= (ovf_i_ff & ~clr_ovf) | set_ovf_i;
    end
  end

  // address push-down stacks: B writes back three reads later, A two
  logic [`ADDR_W-1:0] bstk_ff [B_DEPTH];
  logic [`ADDR_W-1:0] astk_ff [A_DEPTH];
  wire push_b = act & apipe_push & ph0;
  wire push_a = act & apipe_push & ph2;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < B_DEPTH; i++) begin
        bstk_ff[i] <= '0;
      end
      for (int i = 0; i < A_DEPTH; i++) begin
        astk_ff[i] <= '0;
      end
    end else begin
      if (push_b) begin
        bstk_ff[0] <= daddr;
        for (int i = 1; i < B_DEPTH; i++) begin
          bstk_ff[i] <= bstk_ff[i-1];
        end
      end
      if (push_a) begin
        astk_ff[0] <= daddr;
        for (int i = 1; i < A_DEPTH; i++) begin
          astk_ff[i] <= astk_ff[i-1];
        end
      end
    end
  end

  // one memory slot per phase: read B, write B1, read A, write A1
  wire mem_on = run & mem_en;
  wire [`ADDR_W-1:0] req_addr = ph1 ? bstk_ff[B_DEPTH-1] :
                                ph3 ? astk_ff[A_DEPTH-1] : daddr;
  wire signed [`DATA_W-1:0] wr_re = ph1 ? b1r_ff : a1r_ff;
  wire signed [`DATA_W-1:0] wr_im = ph1 ? b1i_ff : a1i_ff;
  // shifter scales results on the way out for block floating point
  wire signed [`DATA_W-1:0] sh_re = wr_re >>> shift_amt;
  wire signed [`DATA_W-1:0] sh_im = wr_im >>> shift_amt;

  // condition sources; bit 0 is the forced pass
  logic [`COND_PIN_W-1:0] cp1_ff;
  logic [`COND_PIN_W-1:0] cp2_ff;
  logic [`COND_PIN_W-1:0] cp3_ff;
  logic [`COND_PIN_W-1:0] cp_ff;
  wire [`COND_PIN_W-1:0] cp_agree = ~(cp2_ff ^ cp3_ff);
  wire [31:0] cond_src = {cp_ff, 11'h000, run, ph0, ovf_i_ff, ovf_r_ff, 1'b1};

  // pins pass three flops; a bit moves only once the last two agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cp1_ff <= '0;
      cp2_ff <= '0;
      cp3_ff <= '0;
      cp_ff <= '0;
    end else begin
      cp1_ff <= cond_pins;
      cp2_ff <= cp1_ff;
      cp3_ff <= cp2_ff;
      cp_ff <= (cp3_ff & cp_agree) | (cp_ff & ~cp_agree);
    end
  end

  // registered outputs, refreshed every core clock
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_req <= '0;
      mem_wdata <= '0;
      coef_addr <= '0;
      seq_ctl <= '0;
      cond_out <= 1'b0;
    end else begin
      mem_req.rd <= mem_on & (ph0 | ph2);
      mem_req.wr <= mem_on & (ph1 | ph3);
      mem_req.addr <= req_addr;
      mem_wdata.re <= sh_re;
      mem_wdata.im <= sh_im;
      coef_addr <= caddr;
      seq_ctl <= seq_field;
      cond_out <= cond_src[ccsel];
    end
  end

  assign ucyc_step = step;

endmodule

// *** sim/fft_bfly_checker.sv ***
`timescale 1ns/1ps
module fft_bfly_checker
  import fft_bfly_pkg::*;
#(
  parameter int BASE_CYC = 29,
  parameter int LONG_CYC = 36
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // design inputs
  input wire logic [127:0] uword,
  input wire cplx_s mem_rdata,
  input wire cplx_s coef_rdata,
  input wire logic [15:0] cond_pins,
  // design outputs
  input wire mem_req_s mem_req,
  input wire cplx_s mem_wdata,
  input wire logic [9:0] coef_addr,
  input wire seq_ctl_s seq_ctl,
  input wire logic cond_out,
  input wire logic ucyc_step
);
  logic up1_ff, up2_ff, seen_ff, any_st_ff, all_st_ff;
  logic [7:0] gap_ff;
  // microword field decode
  wire stretch = uword[114];
  wire run = uword[108];
  wire [4:0] sel = uword[113:109];

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // microcycle length tracking; first step is skipped, its start is reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      up1_ff <= 1'b0;
      up2_ff <= 1'b0;
      seen_ff <= 1'b0;
      gap_ff <= 8'h00;
      any_st_ff <= 1'b0;
      all_st_ff <= 1'b1;
    end else begin
      up1_ff <= 1'b1;
      up2_ff <= up1_ff;
      seen_ff <= seen_ff | ucyc_step;
      gap_ff <= ucyc_step ? 8'h01 : gap_ff + 8'h01;
      any_st_ff <= ucyc_step ? 1'b0 : any_st_ff | stretch;
      all_st_ff <= ucyc_step ? 1'b1 : all_st_ff & stretch;
    end
  end

  sequence s_halt;
    (!run && $stable(uword)) [*2];
  endsequence
  sequence s_pin_hi;
    (sel == 5'h10 && cond_pins[0]) [*5];
  endsequence

  property p_excl;
    !(mem_req.rd && mem_req.wr);
  endproperty
  property p_rd_wr;
    ucyc_step && run && uword[116] && !uword[117] && mem_req.rd |-> ##[1:2] mem_req.wr;
  endproperty
  property p_period;
    ucyc_step && seen_ff |-> gap_ff == BASE_CYC || gap_ff == LONG_CYC;
  endproperty
  property p_short;
    ucyc_step && seen_ff && !any_st_ff |-> gap_ff == BASE_CYC;
  endproperty
  property p_long;
    ucyc_step && seen_ff && all_st_ff |-> gap_ff == LONG_CYC;
  endproperty
  property p_coef;
    up2_ff |-> coef_addr == $past(uword[107:98]);
  endproperty
  property p_seq;
    up2_ff |-> seq_ctl == $past(uword[15:0]);
  endproperty
  property p_pass;
    up2_ff && sel == 5'h00 |=> cond_out;
  endproperty
  property p_pin;
    s_pin_hi |=> cond_out;
  endproperty
  property p_halt;
    s_halt |=> $stable(mem_wdata) && $stable(mem_req);
  endproperty

  a_excl: assert property (p_excl)
    else $error("read and write strobes together");
  a_rd_wr: assert property (p_rd_wr)
    else $error("read phase not followed by write phase");
  a_period: assert property (p_period)
    else $error("microcycle length off");
  a_short: assert property (p_short)
    else $error("base microcycle length off");
  a_long: assert property (p_long)
    else $error("stretched microcycle length off");
  a_coef: assert property (p_coef)
    else $error("coefficient address not one clock late");
  a_seq: assert property (p_seq)
    else $error("sequencer field not passed on");
  a_pass: assert property (p_pass)
    else $error("forced pass not seen");
  a_pin: assert property (p_pin)
    else $error("condition pin not selected");
  a_halt: assert property (p_halt)
    else $error("halted datapath moved");
endmodule

bind fft_butterfly_pipeline fft_bfly_checker #(.BASE_CYC(BASE_CYC), .LONG_CYC(LONG_CYC))
  fft_bfly_checker_inst (.core_clk(core_clk), .arst_n(arst_n), .uword(uword),
  .mem_rdata(mem_rdata), .coef_rdata(coef_rdata), .cond_pins(cond_pins), .mem_req(mem_req),
  .mem_wdata(mem_wdata), .coef_addr(coef_addr), .seq_ctl(seq_ctl), .cond_out(cond_out),
  .ucyc_step(ucyc_step));

// *** sim/fft_mem_model.sv ***
`timescale 1ns/1ps
module fft_mem_model
  import fft_bfly_pkg::*;
(
  // clock and step marker
  input wire logic core_clk,
  input wire logic ucyc_step,
  // data memory side
  input wire mem_req_s mem_req,
  input wire cplx_s mem_wdata,
  output cplx_s mem_rdata,
  // coefficient side
  input wire logic [9:0] coef_addr,
  output cplx_s coef_rdata
);
  cplx_s arr [0:1023];
  cplx_s coef_arr [0:1023];
  logic [31:0] junk_ff = 32'h5a5a_c3c3;
  // async read; an idle bus shows a moving pattern, never the last word
  assign mem_rdata = mem_req.rd ? arr[mem_req.addr] : junk_ff;
  assign coef_rdata = coef_arr[coef_addr];
  // write lands at the microcycle end, when the datapath takes its step
  always @(posedge core_clk) begin
    junk_ff <= ~junk_ff;
    if (ucyc_step && mem_req.wr) begin
      arr[mem_req.addr] <= mem_wdata;
    end
  end
endmodule

// *** sim/fft_butterfly_pipeline_test.sv ***
`timescale 1ns/1ps
module fft_butterfly_pipeline_test
  import fft_bfly_pkg::*;
;
  localparam int NB = 4;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [127:0] uword;
  logic [15:0] cond_pins;
  cplx_s mem_rdata, coef_rdata, mem_wdata;
  mem_req_s mem_req;
  logic [9:0] coef_addr;
  seq_ctl_s seq_ctl;
  logic cond_out, ucyc_step;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;

  // short counts keep the run brief
  fft_butterfly_pipeline #(.BASE_CYC(3), .LONG_CYC(4)) fft_butterfly_pipeline_inst (
    .core_clk(core_clk), .arst_n(arst_n), .uword(uword), .mem_rdata(mem_rdata),
    .mem_req(mem_req), .mem_wdata(mem_wdata), .coef_rdata(coef_rdata), .coef_addr(coef_addr),
    .cond_pins(cond_pins), .seq_ctl(seq_ctl), .cond_out(cond_out), .ucyc_step(ucyc_step));
  fft_mem_model fft_mem_model_inst (.core_clk(core_clk), .ucyc_step(ucyc_step),
    .mem_req(mem_req), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .coef_addr(coef_addr),
    .coef_rdata(coef_rdata));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // small data and twiddles so no sum overflows
  function automatic cplx_s dv(input int a);
    dv = {16'(1024 + 256 * a), 16'(512 - 128 * a)};
  endfunction
  function automatic cplx_s cv(input int c);
    cv = {16'(16384 - 4096 * c), 16'(8192 + 2048 * c)};
  endfunction
  function automatic logic signed [15:0] mq(input logic signed [15:0] x, y);
    logic signed [31:0] p;
    p = x * y;
    mq = p[30:15];
  endfunction
  // all enables, address push and memory enable set, no shift
  function automatic logic [127:0] mk(input int d, k, input logic r, s);
    mk = 128'h0010_0000_0010_0400_0000_2000_0001_0000;
    mk[97:88] = 10'(d);
    mk[107:98] = 10'(k);
    mk[108] = r;
    mk[114] = s;
    mk[15:0] = {12'(k), 4'h3};
  endfunction
  // microcycle m: phases read B, write, read A, write
  function automatic logic [127:0] wfor(input int m, input logic r);
    int k, ph;
    k = m / 4;
    ph = m % 4;
    wfor = mk(ph % 2 ? 0 : (k < NB ? 8 : 200) + 2 * k + (ph == 0), k, r, m % 5 == 2);
  endfunction

  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // next word goes in on the clock after the step is seen
  task automatic next_uc(input logic [127:0] w);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ucyc_step !== 1'b1 && n < 64);
    if (n == 64) err_total++;
    #1 uword = w;
  endtask

  task automatic run_fft();
    cplx_s a, b, w, p;
    // end on a write phase so the halt that follows never splits a read from its write
    for (int m = 1; m <= 4 * NB + 13; m++) next_uc(wfor(m, 1'b1));
    for (int k = 0; k < NB; k++) begin
      a = dv(8 + 2 * k);
      b = dv(9 + 2 * k);
      w = cv(k);
      p.re = mq(b.re, w.re) - mq(b.im, w.im);
      p.im = mq(b.re, w.im) + mq(b.im, w.re);
      chk(fft_mem_model_inst.arr[8 + 2 * k], {a.re + p.re, a.im + p.im});
      chk(fft_mem_model_inst.arr[9 + 2 * k], {a.re - p.re, a.im - p.im});
    end
  endtask

  // with run low the write data and memory request may not move across several microcycles
  task automatic hold_run();
    cplx_s w0;
    mem_req_s r0;
    next_uc(wfor(30, 1'b0));
    repeat (2) @(posedge core_clk);
    #1 w0 = mem_wdata;
    r0 = mem_req;
    repeat (12) @(posedge core_clk);
    #1 chk(mem_wdata, w0);
    chk(32'(mem_req), 32'(r0));
  endtask

  // sync forces phase 0 at the step even while halted
  task automatic sync_phase();
    logic [127:0] w;
    w = wfor(30, 1'b0);
    w[117] = 1'b1;
    w[113:109] = 5'h03;
    next_uc(w);
    repeat (2) @(posedge core_clk);
    #1 chk(32'(cond_out), 32'h0);
    next_uc(w);
    repeat (2) @(posedge core_clk);
    #1 chk(32'(cond_out), 32'h1);
  endtask

  // phase is frozen at two and no overflow occurred
  task automatic cond_sel();
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 32; s++) begin
        @(posedge core_clk);
        #1 cond_pins = p ? 16'h5a3c : 16'ha5c3;
        uword[113:109] = 5'(s);
        repeat (6) @(posedge core_clk);
        #1 chk(32'(cond_out), s == 0 ? 1 : (s >= 16 ? 32'(cond_pins[s - 16]) : 0));
      end
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    uword = 128'h0;
    cond_pins = 16'h0;
    for (int i = 0; i < 1024; i++) begin
      fft_mem_model_inst.arr[i] = dv(i % 16);
      fft_mem_model_inst.coef_arr[i] = cv(i % 8);
    end
    repeat (16) @(posedge core_clk);
    #1 arst_n = 1'b1;
    @(posedge core_clk);
    #1 uword = wfor(0, 1'b0);
    uword[117] = 1'b1; // halted sync word parks the loop at phase 0
    next_uc(wfor(0, 1'b1));
    run_fft();
    hold_run();
    cond_sel();
    sync_phase();
    print_verdict();
  end
endmodule
